// ==== include/ulsf_pkg.sv ====
package ulsf_pkg;

   // Register byte offsets on the Avalon-MM slave
   localparam logic [3:0] ADDR_LINE_STATUS      = 4'h0;
   localparam logic [3:0] ADDR_CONTROL          = 4'h4;
   localparam logic [3:0] ADDR_TRANSMIT_HOLDING = 4'h8;

   // Line status bit positions
   localparam int LS_THRE_BIT = 5;
   localparam int LS_BRK_BIT  = 4;
   localparam int LS_FE_BIT   = 3;
   localparam int LS_PE_BIT   = 2;

   // Control register reset value
   localparam logic [6:0] CONTROL_RESET = 7'h00;

   // Word length codes: 5, 6, 7 or 8 data bits
   localparam logic [1:0] WLEN_5 = 2'h0;
   localparam logic [1:0] WLEN_6 = 2'h1;
   localparam logic [1:0] WLEN_7 = 2'h2;
   localparam logic [1:0] WLEN_8 = 2'h3;

   // Data bit masks for each word length
   localparam logic [7:0] MASK_5 = 8'h1f;
   localparam logic [7:0] MASK_6 = 8'h3f;
   localparam logic [7:0] MASK_7 = 8'h7f;
   localparam logic [7:0] MASK_8 = 8'hff;

   // Software control fields, high bit first
   typedef struct packed {
      logic       two_stop;
      logic [1:0] word_len;
      logic       even_par;
      logic       par_en;
      logic       thre_ie;
      logic       fifo_en;
   } ulsf_ctrl_s;

   // Character as the receive checker hands it over
   typedef struct packed {
      logic [7:0] data;
      logic       parity;
      logic [1:0] stop;
   } ulsf_rx_char_s;

   // Error flags kept with each received character
   typedef struct packed {
      logic brk;
      logic fe;
      logic pe;
   } ulsf_flags_s;

   // Break tracking, one Gray step
   typedef enum logic [0:0] {
      BRK_IDLE = 1'b0,
      BRK_HOLD = 1'b1
   } ulsf_brk_e;

endpackage

// ==== src/ulsf_top.sv ====
// How it works
// - No FIFO: holding-empty sets when the character moves to the shifter.
// - No FIFO: holding-empty clears as the CPU writes the holding register.
// - FIFO: holding-empty follows an empty transmit FIFO, clears on a write.
// - Interrupt request while holding-empty is set and its enable is on.
// - Break flag sets when a frame up to its first stop bit is received low.
// - FIFO: only one character is stored for each break, however long.
// - Framing error sets when a used stop bit is sampled low.
// - Parity error sets when parity disagrees with the programmed mode.
// - FIFO: error flags are stored per entry and shown for the head entry.
// - Break, framing and parity flags are zero after reset and when absent.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
module ulsf_top #(
   parameter int DEPTH = 16
) (
   input  wire logic                   ref_clk,
   input  wire logic                   rst,
   input  wire logic [3:0]             avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [31:0]            avs_writedata,
   output logic      [31:0]            avs_readdata,
   output logic                        avs_waitrequest,
   output logic                        tx_load,
   output logic      [7:0]             tx_load_data,
   input  wire logic                   tx_transfer,
   input  wire logic                   tx_fifo_empty,
   input  wire logic                   rx_char_valid,
   input  wire ulsf_pkg::ulsf_rx_char_s rx_char,
   input  wire logic                   rx_line,
   output logic                        rx_push,
   output logic      [7:0]             rx_push_data,
   input  wire logic                   rx_pop,
   output logic                        thre_irq
);

   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] CNT_FULL = (PW+1)'(DEPTH);
   localparam logic [PW:0] CNT_ZERO = '0;
   localparam logic [PW:0] CNT_ONE  = (PW+1)'(1);
   localparam logic [PW-1:0] PTR_ONE = PW'(1);

   // Data bit mask for the programmed word length
   function automatic logic [7:0] wmask(input logic [1:0] wl);
      unique case (wl)
         ulsf_pkg::WLEN_5: wmask = ulsf_pkg::MASK_5;
         ulsf_pkg::WLEN_6: wmask = ulsf_pkg::MASK_6;
         ulsf_pkg::WLEN_7: wmask = ulsf_pkg::MASK_7;
         ulsf_pkg::WLEN_8: wmask = ulsf_pkg::MASK_8;
      endcase
   endfunction

   ulsf_pkg::ulsf_ctrl_s  ctrl_reg;
   logic                  ack_reg;
   logic [31:0]           rdata_reg;
   logic                  thre_reg;
   ulsf_pkg::ulsf_flags_s flags_reg;
   ulsf_pkg::ulsf_flags_s flags_next;
   logic                  present;
   ulsf_pkg::ulsf_brk_e   brk_state_reg;
   ulsf_pkg::ulsf_flags_s mem [DEPTH];
   logic [PW-1:0]         wr_ptr_reg;
   logic [PW-1:0]         rd_ptr_reg;
   logic [PW:0]           count_reg;
   logic                  tx_load_reg;
   logic [7:0]            tx_data_reg;
   logic                  push_reg;
   logic [7:0]            push_data_reg;
   logic                  fresh_reg;

   // Bus handshake: every access waits one cycle
   logic req;
   logic acc;
   logic rd_status;
   logic wr_holding;
   logic wr_control;
   assign req        = avs_read | avs_write;
   assign acc        = req & ack_reg;
   assign rd_status  = acc & avs_read
                       & (avs_address == ulsf_pkg::ADDR_LINE_STATUS);
   assign wr_holding = acc & avs_write
                       & (avs_address == ulsf_pkg::ADDR_TRANSMIT_HOLDING);
   assign wr_control = acc & avs_write
                       & (avs_address == ulsf_pkg::ADDR_CONTROL);
   assign avs_waitrequest = req & ~ack_reg;
   assign avs_readdata    = rdata_reg;

   // Acknowledge pulses in the cycle after a request appears
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= req & ~ack_reg;
      end
   end

   // Read data captured while waitrequest is high
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata_reg <= 32'h0000_0000;
      end else if (avs_read & ~ack_reg) begin
         rdata_reg <= 32'h0000_0000;
         if (avs_address == ulsf_pkg::ADDR_LINE_STATUS) begin
            rdata_reg[ulsf_pkg::LS_THRE_BIT] <= thre_reg;
            rdata_reg[ulsf_pkg::LS_BRK_BIT]  <= flags_reg.brk;
            rdata_reg[ulsf_pkg::LS_FE_BIT]   <= flags_reg.fe;
            rdata_reg[ulsf_pkg::LS_PE_BIT]   <= flags_reg.pe;
         end else if (avs_address == ulsf_pkg::ADDR_CONTROL) begin
            rdata_reg[6:0] <= ctrl_reg;
         end
      end
   end

   // Control register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl_reg <= ulsf_pkg::CONTROL_RESET;
      end else if (wr_control) begin
         ctrl_reg <= avs_writedata[6:0];
      end
   end

   // Holding register load strobe and data towards the transmitter
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tx_load_reg <= 1'b0;
         tx_data_reg <= 8'h00;
      end else begin
         tx_load_reg <= wr_holding;
         if (wr_holding) begin
            tx_data_reg <= avs_writedata[7:0];
         end
      end
   end
   assign tx_load      = tx_load_reg;
   assign tx_load_data = tx_data_reg;

   // Holding-empty flag; a load beats a transfer in the same cycle
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         thre_reg <= 1'b1;
      end else if (wr_holding) begin
         thre_reg <= 1'b0;
      end else if (ctrl_reg.fifo_en) begin
         thre_reg <= tx_fifo_empty;
      end else if (tx_transfer) begin
         thre_reg <= 1'b1;
      end
   end

   // Interrupt request
   assign thre_irq = thre_reg & ctrl_reg.thre_ie;

   // Checks on the incoming character
   logic [7:0]            dmask;
   logic                  par_calc;
   logic                  stop_bad;
   logic                  line_low;
   ulsf_pkg::ulsf_flags_s cur;
   always_comb begin
      dmask    = wmask(ctrl_reg.word_len);
      par_calc = ^(rx_char.data & dmask) ^ ~ctrl_reg.even_par;
      stop_bad = ~rx_char.stop[0] | (ctrl_reg.two_stop & ~rx_char.stop[1]);
      line_low = ((rx_char.data & dmask) == 8'h00)
                 & ~(ctrl_reg.par_en & rx_char.parity)
                 & ~rx_char.stop[0];
      cur.brk  = line_low;
      cur.fe   = stop_bad;
      cur.pe   = ctrl_reg.par_en & (rx_char.parity != par_calc);
   end

   // One break character per low period
   logic take;
   assign take = rx_char_valid
                 & ~((brk_state_reg == ulsf_pkg::BRK_HOLD) & cur.brk);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         brk_state_reg <= ulsf_pkg::BRK_IDLE;
      end else begin
         unique case (brk_state_reg)
            ulsf_pkg::BRK_IDLE: begin
               if (take & cur.brk) begin
                  brk_state_reg <= ulsf_pkg::BRK_HOLD;
               end
            end
            ulsf_pkg::BRK_HOLD: begin
               if (rx_line) begin
                  brk_state_reg <= ulsf_pkg::BRK_IDLE;
               end
            end
         endcase
      end
   end

   // Per-entry flag store mirroring the receive FIFO
   logic push;
   logic pop;
   assign push = take & ctrl_reg.fifo_en & (count_reg != CNT_FULL);
   assign pop  = rx_pop & ctrl_reg.fifo_en & (count_reg != CNT_ZERO);

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= cur;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst | ~ctrl_reg.fifo_en) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= CNT_ZERO;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + PTR_ONE;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + PTR_ONE;
         end
         if (push & ~pop) begin
            count_reg <= count_reg + CNT_ONE;
         end else if (pop & ~push) begin
            count_reg <= count_reg - CNT_ONE;
         end
      end
   end

   // Character handed to the data FIFO
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         push_reg      <= 1'b0;
         push_data_reg <= 8'h00;
      end else begin
         push_reg <= push;
         if (push) begin
            push_data_reg <= rx_char.data & dmask;
         end
      end
   end
   assign rx_push      = push_reg;
   assign rx_push_data = push_data_reg;

   // Flags for the character now presented to software
   always_comb begin
      present    = 1'b0;
      flags_next = '0;
      if (~ctrl_reg.fifo_en) begin
         present    = take;
         flags_next = cur;
      end else if (pop & (count_reg > CNT_ONE)) begin
         present    = 1'b1;
         flags_next = mem[rd_ptr_reg + PTR_ONE];
      end else if (push & ((count_reg == CNT_ZERO) | pop)) begin
         present    = 1'b1;
         flags_next = cur;
      end else if (pop) begin
         present    = 1'b1;
      end
   end

   // Set when a character is shown after the last read data was captured
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fresh_reg <= 1'b0;
      end else if (present) begin
         fresh_reg <= 1'b1;
      end else if (avs_read & ~ack_reg) begin
         fresh_reg <= 1'b0;
      end
   end

   // Shown flags: a new character wins over a status read
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         flags_reg <= '0;
      end else if (present) begin
         flags_reg <= flags_next;
      end else if (rd_status & ~fresh_reg) begin
         flags_reg <= '0;
      end
   end

   // Sequences for the multi-step checks
   sequence holding_write_s;
      wr_holding;
   endsequence

   sequence break_char_s;
      take & cur.brk;
   endsequence

   sequence break_held_s;
      (brk_state_reg == ulsf_pkg::BRK_HOLD) & ~rx_line;
   endsequence

   sequence status_capture_s;
      avs_read & ~ack_reg
      & (avs_address == ulsf_pkg::ADDR_LINE_STATUS);
   endsequence

   // Properties, one or more per rule
   thre_set_a: assert property (@(posedge ref_clk) disable iff (rst)
      tx_transfer & ~wr_holding & ~ctrl_reg.fifo_en |=> thre_reg)
      else $error("holding-empty not set on transfer");

   thre_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
      holding_write_s |=> ~thre_reg & tx_load)
      else $error("holding-empty not cleared on load");

   thre_fifo_a: assert property (@(posedge ref_clk) disable iff (rst)
      ctrl_reg.fifo_en & ~wr_holding & ~wr_control
      |=> thre_reg == $past(tx_fifo_empty))
      else $error("holding-empty not tracking fifo empty");

   irq_req_a: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(thre_reg) & ctrl_reg.thre_ie |-> thre_irq)
      else $error("holding-empty interrupt missing");

   brk_set_a: assert property (@(posedge ref_clk) disable iff (rst)
      break_char_s ##0 ~ctrl_reg.fifo_en |=> flags_reg.brk)
      else $error("break flag not set");

   brk_once_a: assert property (@(posedge ref_clk) disable iff (rst)
      break_held_s ##0 (rx_char_valid & cur.brk)
      |=> ~rx_push)
      else $error("second break character stored");

   fe_set_a: assert property (@(posedge ref_clk) disable iff (rst)
      take & cur.fe & ~ctrl_reg.fifo_en |=> flags_reg.fe)
      else $error("framing error not set");

   pe_set_a: assert property (@(posedge ref_clk) disable iff (rst)
      take & cur.pe & ~ctrl_reg.fifo_en |=> flags_reg.pe)
      else $error("parity error not set");

   head_flags_a: assert property (@(posedge ref_clk) disable iff (rst)
      push & (count_reg == CNT_ZERO) & ~rx_pop
      |=> (flags_reg == $past(cur)) & rx_push)
      else $error("head flags not shown");

   status_bits_a: assert property (@(posedge ref_clk) disable iff (rst)
      status_capture_s
      |=> (avs_readdata[ulsf_pkg::LS_THRE_BIT] == $past(thre_reg))
          & (avs_readdata[ulsf_pkg::LS_BRK_BIT] == $past(flags_reg.brk))
          & (avs_readdata[ulsf_pkg::LS_FE_BIT] == $past(flags_reg.fe))
          & (avs_readdata[ulsf_pkg::LS_PE_BIT] == $past(flags_reg.pe)))
      else $error("status bits not reported");

   flags_reset_a: assert property (@(posedge ref_clk)
      rst |=> flags_reg == '0)
      else $error("flags not zero after reset");

   read_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
      rd_status & ~present & ~fresh_reg |=> flags_reg == '0)
      else $error("flags not cleared by status read");

endmodule

// ==== tb/ulsf_rx_model.sv ====
module ulsf_rx_model (
   input  wire logic                    ref_clk,
   input  wire logic                    rst,
   input  wire logic                    send,
   input  wire ulsf_pkg::ulsf_rx_char_s send_char,
   input  wire logic                    hold_low,
   output logic                         rx_char_valid,
   output ulsf_pkg::ulsf_rx_char_s      rx_char,
   output logic                         rx_line
);
   timeunit 1ns;
   timeprecision 1ps;

   // Finished characters from the remote sender, one cycle each
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rx_char_valid <= 1'b0;
         rx_char       <= '0;
      end else begin
         rx_char_valid <= send;
         rx_char       <= send_char;
      end
   end

   // Line idles high and stays low while the sender holds a break
   assign rx_line = ~hold_low;
endmodule

// ==== tb/ulsf_top_tb.sv ====
module ulsf_top_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic                    ref_clk;
   logic                    rst;
   logic [3:0]              avs_address;
   logic                    avs_read;
   logic                    avs_write;
   logic [31:0]             avs_writedata;
   logic [31:0]             avs_readdata;
   logic                    avs_waitrequest;
   logic                    tx_load;
   logic [7:0]              tx_load_data;
   logic                    tx_transfer;
   logic                    tx_fifo_empty;
   logic                    rx_char_valid;
   ulsf_pkg::ulsf_rx_char_s rx_char;
   logic                    rx_line;
   logic                    rx_push;
   logic [7:0]              rx_push_data;
   logic                    rx_pop;
   logic                    thre_irq;
   logic                    send;
   ulsf_pkg::ulsf_rx_char_s send_c;
   logic                    hold_low;
   logic [31:0]             rd;
   int                      mismatches;
   int                      checked;
   int                      pushes;
   int                      loads;
   logic [7:0]              push_last;

   ulsf_top #(.DEPTH(16)) dut_u (
      .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .tx_load(tx_load),
      .tx_load_data(tx_load_data), .tx_transfer(tx_transfer),
      .tx_fifo_empty(tx_fifo_empty), .rx_char_valid(rx_char_valid),
      .rx_char(rx_char), .rx_line(rx_line), .rx_push(rx_push),
      .rx_push_data(rx_push_data), .rx_pop(rx_pop), .thre_irq(thre_irq)
   );

   ulsf_rx_model rx_u (
      .ref_clk(ref_clk), .rst(rst), .send(send), .send_char(send_c),
      .hold_low(hold_low), .rx_char_valid(rx_char_valid),
      .rx_char(rx_char), .rx_line(rx_line)
   );

   // 25 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // Strobes seen at the FIFO and transmit sides
   always @(posedge ref_clk) begin
      if (rx_push === 1'b1) begin
         pushes++;
         push_last = rx_push_data;
      end
      if (tx_load === 1'b1) begin
         loads++;
      end
   end

   task automatic complete_run();
      if (mismatches == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp,
                      input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // Avalon-MM access, held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] wd, output logic [31:0] d);
      int n;
      n = 0;
      avs_address   <= a;
      avs_writedata <= wd;
      avs_read      <= ~wr;
      avs_write     <= wr;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0 && n < 20) begin
         @(posedge ref_clk);
         n++;
      end
      d = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 20) begin
         mismatches++;
         complete_run();
      end
      @(posedge ref_clk);
   endtask

   task automatic status(input logic [31:0] exp);
      bus(1'b0, ulsf_pkg::ADDR_LINE_STATUS, 32'h0000_0000, rd);
      chk("line_status", exp, rd);
   endtask

   task automatic wreg(input logic [3:0] a, input logic [31:0] v);
      bus(1'b1, a, v, rd);
      tick(1);
   endtask

   task automatic rx_send(input logic [7:0] dat, input logic par,
                          input logic [1:0] stp);
      send   <= 1'b1;
      send_c <= '{data: dat, parity: par, stop: stp};
      tick(1);
      send   <= 1'b0;
      tick(3);
   endtask

   initial begin
      mismatches = 0;
      checked = 0;
      pushes = 0;
      loads = 0;
      push_last = 8'h00;
      rst = 1'b1;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      tx_transfer = 1'b0;
      tx_fifo_empty = 1'b1;
      rx_pop = 1'b0;
      send = 1'b0;
      send_c = '0;
      hold_low = 1'b0;
      tick(2);
      rst <= 1'b0;
      tick(1);
      // Reset state, then no FIFO, even parity, 8 bits, interrupt on
      status(32'h0000_0020);
      bus(1'b1, 4'h2, 32'h0000_00ff, rd);
      tick(1);
      wreg(ulsf_pkg::ADDR_CONTROL, 32'h0000_003e);
      bus(1'b0, ulsf_pkg::ADDR_CONTROL, 32'h0000_0000, rd);
      chk("control", 32'h0000_003e, rd);
      chk("irq_set", 32'h1, {31'h0, thre_irq});
      wreg(ulsf_pkg::ADDR_TRANSMIT_HOLDING, 32'h0000_005a);
      chk("load_data", 32'h5a, {24'h0, tx_load_data});
      chk("irq_clear", 32'h0, {31'h0, thre_irq});
      chk("loads", 32'h1, loads);
      status(32'h0000_0000);
      tx_transfer <= 1'b1;
      tick(1);
      tx_transfer <= 1'b0;
      tick(2);
      status(32'h0000_0020);
      // Receive errors; only the parity error is checked cleared by the next status read
      rx_send(8'h01, 1'b0, 2'b11);
      status(32'h0000_0024);
      status(32'h0000_0020);
      rx_send(8'h03, 1'b0, 2'b10);
      status(32'h0000_0028);
      rx_send(8'h03, 1'b0, 2'b11);
      status(32'h0000_0020);
      hold_low <= 1'b1;
      rx_send(8'h00, 1'b0, 2'b00);
      status(32'h0000_0038);
      hold_low <= 1'b0;
      tick(2);
      // Odd parity, 5 bits, two stop bits: upper data bits ignored
      wreg(ulsf_pkg::ADDR_CONTROL, 32'h0000_0046);
      bus(1'b0, ulsf_pkg::ADDR_CONTROL, 32'h0000_0000, rd);
      chk("control", 32'h0000_0046, rd);
      rx_send(8'he1, 1'b0, 2'b01);
      status(32'h0000_0028);
      // FIFO mode: holding-empty follows the transmit FIFO
      wreg(ulsf_pkg::ADDR_CONTROL, 32'h0000_003f);
      tx_fifo_empty <= 1'b0;
      tick(2);
      status(32'h0000_0000);
      tx_fifo_empty <= 1'b1;
      tick(2);
      status(32'h0000_0020);
      // One stored character per break, flags shown for the head
      pushes = 0;
      hold_low <= 1'b1;
      rx_send(8'h00, 1'b0, 2'b00);
      rx_send(8'h00, 1'b0, 2'b00);
      chk("break_pushes", 32'h1, pushes);
      status(32'h0000_0038);
      hold_low <= 1'b0;
      tick(2);
      rx_send(8'h01, 1'b0, 2'b11);
      chk("pushes", 32'h2, pushes);
      chk("push_data", 32'h01, {24'h0, push_last});
      rx_pop <= 1'b1;
      tick(1);
      rx_pop <= 1'b0;
      tick(2);
      status(32'h0000_0024);
      complete_run();
   end
endmodule
